// file: rbc_pkg.sv
// Purpose: shared constants, types and carriers of the receive bit-check codec
// Assumes: 20 MHz system clock
// Notes:   timing counts are derived here from times in their own unit
package rbc_pkg;

   // system clock period
   localparam int CLK_NS          = 50;
   // bit-check clock period and its length in system cycles
   localparam int CHECK_PERIOD_NS = 1000;
   localparam logic [7:0] CHECK_DIV =
      8'((CHECK_PERIOD_NS + CLK_NS - 1) / CLK_NS);
   // signal processing start-up time and its cycle count
   localparam int STARTUP_NS      = 100000;
   localparam logic [11:0] STARTUP_CYC =
      12'((STARTUP_NS + CLK_NS - 1) / CLK_NS);

   // data widths and depths
   localparam int BYTE_W     = 8;
   localparam int BUF_DEPTH  = 16;
   localparam int FIFO_DEPTH = 4;

   // interval counter saturation value
   localparam logic [7:0] IV_SAT = 8'hff;
   // edge-to-edge checks for each bit-count selection
   localparam logic [4:0] CHECKS_0 = 5'h00;
   localparam logic [4:0] CHECKS_3 = 5'h06;
   localparam logic [4:0] CHECKS_6 = 5'h0c;
   localparam logic [4:0] CHECKS_9 = 5'h12;
   // byte count thresholds per interrupt level
   localparam logic [4:0] IRQ_LVL0 = 5'h01;
   localparam logic [4:0] IRQ_LVL1 = 5'h04;
   localparam logic [4:0] IRQ_LVL2 = 5'h08;
   localparam logic [4:0] IRQ_LVL3 = 5'h0c;
   // buffer full level and last bit index of a byte
   localparam logic [4:0] BUF_FULL = 5'h10;
   localparam logic [2:0] LAST_BIT = 3'h7;
   // operating mode codes
   localparam logic [1:0] OPM_RX      = 2'h3;
   localparam logic [1:0] OPM_POLLING = 2'h2;

   // receive sequencer states
   typedef enum logic [2:0] {
      RBC_OFF,
      RBC_STARTUP,
      RBC_CHECK,
      RBC_RECV,
      RBC_SLEEP
   } rbc_state_t;

   // configuration bits from the control registers
   typedef struct packed {
      logic [1:0] op_mode;           // op_mode_bit1, op_mode_bit0
      logic       t_mode;            // transparent mode
      logic       p_mode;            // pattern mode
      logic       modulation_select; // 1 ask, 0 fsk
      logic [1:0] nbit_sel;          // bits to check: 0,3,6,9
      logic [1:0] irq_level;         // irq_level_bit1, irq_level_bit0
      logic [5:0] lim_min;           // lower interval limit
      logic [5:0] lim_max;           // upper interval limit
   } rbc_cfg_t;

   // byte read port toward the serial interface
   typedef struct packed {
      logic              valid;
      logic [BYTE_W-1:0] data;
   } rbc_byte_t;

endpackage : rbc_pkg

// file: rbc_fifo.sv
// Purpose: small shift-register fifo between data buffer and read port
// Assumes: single clock, synchronous active-low reset
// Notes:   head entry and flags are flops, so outputs need no mux
`timescale 1ns/1ps
`default_nettype none
module rbc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input  wire logic             clk_i,       // system clock
   input  wire logic             rst_n_i,     // sync reset, active low
   input  wire logic             flush_i,     // drop all entries
   input  wire logic             in_valid_i,  // write request
   output var  logic             in_ready_o,  // space available
   input  wire logic [WIDTH-1:0] in_data_i,   // write data
   output var  logic             out_valid_o, // head holds data
   input  wire logic             out_ready_i, // reader takes head
   output var  logic [WIDTH-1:0] out_data_o   // head data
);

   // whole fifo state
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;  // entries, head at index 0
      logic [DEPTH-1:0]            vld;  // entry valid flags
   } rbc_fifo_st_t;

   rbc_fifo_st_t st_reg;   // registered state
   rbc_fifo_st_t st_next;  // next state

   logic push;  // accepted write
   logic pop;   // accepted read
   logic placed; // write slot already taken this cycle

   // shift on pop, write into first free slot
   always_comb begin
      st_next = st_reg;
      placed  = 1'b0;
      push    = in_valid_i & ~st_reg.vld[DEPTH-1];
      pop     = out_ready_i & st_reg.vld[0];
      if (pop) begin
         st_next.mem = st_reg.mem >> WIDTH;
         st_next.vld = st_reg.vld >> 1;
      end
      // only the first free slot takes the word, never the ones behind it
      if (push) begin
         for (int i = 0; i < DEPTH; i++) begin
            if (!placed && !st_next.vld[i]) begin
               st_next.mem[i] = in_data_i;
               st_next.vld[i] = 1'b1;
               placed         = 1'b1;
            end
         end
      end
      if (flush_i) begin
         st_next.vld = '0;
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign in_ready_o  = ~st_reg.vld[DEPTH-1];
   assign out_valid_o = st_reg.vld[0];
   assign out_data_o  = st_reg.mem[0];

endmodule : rbc_fifo
`default_nettype wire

// file: rbc_rx.sv
// Purpose: receive bit check, manchester decoding and byte buffering
// Assumes: demodulated data and chip select arrive asynchronously
// Notes:   control bits come from the register file on the same clock
`timescale 1ns/1ps
`default_nettype none

// How it works
// - bit count selects 0/6/12/18 checks
// - interval outside window ends the check
// - six-bit limits in check clock units
// - counter ticks per check period, limits compared
// - success sets supply and clock enables
// - entry interrupt only without transparent/pattern mode
// - transparent mode drives data on serial pin
// - non-transparent mode buffers decoded data
// - only T and 2T intervals accepted
// - 2T bounds derived from limits, rounded up
// - bytes stored after start bit, inclusive
// - sixteen-byte buffer, newest overwrites oldest
// - byte count up on receive, down on read
// - interrupt when rising count hits level
// - bit error interrupts, returns to start-up
// - missing centre edge is a bit error
// - errored byte is never stored
// - control write resets buffer and count
// - receive mode still set restarts start-up
// - rising demod edge decodes as one
// - pin released when not transparent
module rbc_rx (
   input  wire logic              clk_i,              // system clock
   input  wire logic              rst_n_i,            // sync reset, active low
   input  wire logic              demod_i,            // demodulator output pin
   input  wire logic              cs_n_i,             // serial chip select pin
   input  wire rbc_pkg::rbc_cfg_t cfg_i,              // control register bits
   input  wire logic              ctrl_write_i,       // write to regs 1,4,5,6
   input  wire logic              wake_i,             // polling timer wake pulse
   input  wire logic              irq_clear_i,        // status read clears irq
   input  wire logic              rd_ready_i,         // host takes a byte
   output var  logic              rd_valid_o,         // byte available
   output var  logic [7:0]        rd_data_o,          // byte to host
   output var  logic [4:0]        byte_count_o,       // received byte count
   output var  logic              irq_o,              // interrupt pin
   output var  logic              supply_out_enable_o, // supply output enable
   output var  logic              clk_out_enable_o,   // clock output enable
   output var  logic              sleep_o,            // in sleep mode
   output var  logic              receiving_o,        // in receiving mode
   output var  logic              serial_out_pin_o,   // serial data out level
   output var  logic              serial_out_oe_n_o   // low while pin driven
);

   // whole block state
   typedef struct packed {
      logic                     dm_s1;      // demod sync stage 1
      logic                     dm_s2;      // demod sync stage 2
      logic                     dm_d;       // delayed for edge detect
      logic                     cs_s1;      // chip select sync stage 1
      logic                     cs_s2;      // chip select sync stage 2
      rbc_pkg::rbc_state_t      state;      // sequencer state
      logic [7:0]               div_cnt;    // check clock divider
      logic [7:0]               iv_cnt;     // interval_count
      logic [11:0]              su_cnt;     // start-up timer
      logic                     seen_edge;  // first edge of check taken
      logic [4:0]               chk_cnt;    // passed checks
      logic                     synced;     // start bit found
      logic                     at_center;  // last edge was a bit centre
      logic [7:0]               shift;      // byte being assembled
      logic [2:0]               bit_cnt;    // bits in shift
      logic [15:0][7:0]         bufm;       // data buffer
      logic [3:0]               wr_ptr;     // buffer write index
      logic [3:0]               rd_ptr;     // buffer read index
      logic [4:0]               fill;       // bytes held in buffer
      logic [4:0]               byte_cnt;   // bytes held in buffer and fifo
      logic                     irq;        // interrupt pin level
      logic                     sup_en;     // supply_out_enable
      logic                     clk_en;     // clock output enable
      logic                     sdo;        // serial_out_pin level
      logic                     sdo_oe_n;   // serial pin enable, low drives
      logic                     sleep;      // sleep mode flag
      logic                     recv;       // receiving mode flag
   } rbc_st_t;

   rbc_st_t r_reg;   // registered state
   rbc_st_t r_next;  // next state

   logic       edge_det;   // demod edge seen
   logic       rising;     // edge was low to high
   logic       tick;       // one check clock period elapsed
   logic [7:0] lim_lo;     // T lower bound
   logic [7:0] lim_hi;     // T upper bound
   logic [7:0] dbl_sum;    // lim_min + lim_max
   logic [7:0] dbl_diff;   // lim_max - lim_min
   logic [7:0] double_interval_low;   // 2T lower bound
   logic [7:0] double_interval_high;  // 2T upper bound
   logic [4:0] chk_target; // checks required
   logic [4:0] irq_thr;    // count threshold
   logic       is_t;       // interval is T
   logic       is_2t;      // interval is 2T
   logic       bit_rec;    // decoded bit valid
   logic       store;      // full byte ready
   logic [7:0] store_byte; // byte to store
   logic       enter_rx;   // bit check passed
   logic       rx_err;     // bit error in receiving mode
   logic       fifo_ready; // fifo has room
   logic       push;       // buffer to fifo move
   logic       overwrite;  // store into full buffer
   logic       host_take;  // host handshake
   logic       irq_set;    // interrupt event this cycle

   // limits and their 2T derivation
   always_comb begin
      lim_lo   = {2'h0, cfg_i.lim_min};
      lim_hi   = {2'h0, cfg_i.lim_max};
      dbl_sum  = lim_lo + lim_hi;
      dbl_diff = lim_hi - lim_lo;
      // half of an odd difference rounds each bound up
      double_interval_low  = dbl_sum - {1'b0, dbl_diff[7:1]};
      double_interval_high = dbl_sum + 8'({1'b0, dbl_diff[7:1]} + {7'h0, dbl_diff[0]});
      is_t  = (r_reg.iv_cnt >= lim_lo) && (r_reg.iv_cnt < lim_hi);
      is_2t = (r_reg.iv_cnt >= double_interval_low)
              && (r_reg.iv_cnt < double_interval_high);
      unique case (cfg_i.nbit_sel)
         2'h0: chk_target = rbc_pkg::CHECKS_0;
         2'h1: chk_target = rbc_pkg::CHECKS_3;
         2'h2: chk_target = rbc_pkg::CHECKS_6;
         2'h3: chk_target = rbc_pkg::CHECKS_9;
      endcase
      unique case (cfg_i.irq_level)
         2'h0: irq_thr = rbc_pkg::IRQ_LVL0;
         2'h1: irq_thr = rbc_pkg::IRQ_LVL1;
         2'h2: irq_thr = rbc_pkg::IRQ_LVL2;
         2'h3: irq_thr = rbc_pkg::IRQ_LVL3;
      endcase
   end

   // sequencer, decoder and buffer next state
   always_comb begin
      r_next     = r_reg;
      bit_rec    = 1'b0;
      store      = 1'b0;
      store_byte = '0;
      enter_rx   = 1'b0;
      rx_err     = 1'b0;
      // two-flop synchronisers on the pins
      r_next.dm_s1 = demod_i;
      r_next.dm_s2 = r_reg.dm_s1;
      r_next.dm_d  = r_reg.dm_s2;
      r_next.cs_s1 = cs_n_i;
      r_next.cs_s2 = r_reg.cs_s1;
      edge_det = r_reg.dm_s2 ^ r_reg.dm_d;
      rising   = r_reg.dm_s2 & ~r_reg.dm_d;
      // check clock period divider
      tick = (r_reg.div_cnt == rbc_pkg::CHECK_DIV - 8'h01);
      r_next.div_cnt = tick ? '0 : r_reg.div_cnt + 8'h01;
      // interval counter, cleared at each edge
      if (edge_det) begin
         r_next.iv_cnt = '0;
         r_next.div_cnt = '0;
      end else if (tick && r_reg.iv_cnt != rbc_pkg::IV_SAT) begin
         r_next.iv_cnt = r_reg.iv_cnt + 8'h01;
      end
      // serial pin released unless transparent reception
      r_next.sdo      = 1'b0;
      r_next.sdo_oe_n = 1'b1;

      unique case (r_reg.state)
         rbc_pkg::RBC_OFF: begin
            if (cfg_i.op_mode[1]) begin
               r_next.state  = rbc_pkg::RBC_STARTUP;
               r_next.su_cnt = '0;
            end
         end
         rbc_pkg::RBC_STARTUP: begin
            r_next.su_cnt = r_reg.su_cnt + 12'h001;
            if (r_reg.su_cnt == rbc_pkg::STARTUP_CYC - 12'h001) begin
               r_next.state     = rbc_pkg::RBC_CHECK;
               r_next.seen_edge = 1'b0;
               r_next.chk_cnt   = '0;
            end
         end
         rbc_pkg::RBC_CHECK: begin
            if (chk_target == rbc_pkg::CHECKS_0) begin
               enter_rx = 1'b1;
            end else if (edge_det) begin
               r_next.seen_edge = 1'b1;
               if (r_reg.seen_edge) begin
                  if (r_reg.iv_cnt < lim_lo) begin
                     r_next.state = rbc_pkg::RBC_SLEEP;
                  end else begin
                     r_next.chk_cnt = r_reg.chk_cnt + 5'h01;
                     if (r_reg.chk_cnt + 5'h01 == chk_target) begin
                        enter_rx = 1'b1;
                     end
                  end
               end
            end else if (r_reg.seen_edge && r_reg.iv_cnt >= lim_hi) begin
               r_next.state = rbc_pkg::RBC_SLEEP;
            end
            // continuous receive mode retries at once instead of sleeping
            if (r_next.state == rbc_pkg::RBC_SLEEP && cfg_i.op_mode == rbc_pkg::OPM_RX) begin
               r_next.state     = rbc_pkg::RBC_CHECK;
               r_next.seen_edge = 1'b0;
               r_next.chk_cnt   = '0;
            end
            if (enter_rx) begin
               r_next.state     = rbc_pkg::RBC_RECV;
               r_next.sup_en    = 1'b1;
               r_next.clk_en    = 1'b1;
               r_next.synced    = 1'b0;
               r_next.at_center = 1'b0;
               r_next.bit_cnt   = '0;
               if (!cfg_i.t_mode && !cfg_i.p_mode) begin
                  r_next.irq = 1'b1;
               end
            end
         end
         rbc_pkg::RBC_RECV: begin
            if (cfg_i.t_mode) begin
               // raw stream straight onto the pin while chip select is low
               r_next.sdo      = r_reg.dm_s2;
               r_next.sdo_oe_n = r_reg.cs_s2;
            end else if (edge_det) begin
               if (is_t) begin
                  if (r_reg.synced) begin
                     r_next.at_center = ~r_reg.at_center;
                     bit_rec = ~r_reg.at_center;
                  end
               end else if (is_2t) begin
                  // first 2T ends on the centre of the start bit
                  if (!r_reg.synced) begin
                     r_next.synced    = 1'b1;
                     r_next.at_center = 1'b1;
                     bit_rec          = 1'b1;
                  end else if (r_reg.at_center) begin
                     bit_rec = 1'b1;
                  end else begin
                     rx_err = 1'b1;
                  end
               end else begin
                  rx_err = 1'b1;
               end
            end else if (r_reg.iv_cnt >= double_interval_high) begin
               rx_err = 1'b1;
            end
            // shift decoded bit in msb first
            if (bit_rec) begin
               r_next.shift   = {r_reg.shift[6:0], rising};
               r_next.bit_cnt = r_reg.bit_cnt + 3'h1;
               if (r_reg.bit_cnt == rbc_pkg::LAST_BIT) begin
                  store      = 1'b1;
                  store_byte = {r_reg.shift[6:0], rising};
               end
            end
            // partial byte is dropped on error
            if (rx_err) begin
               r_next.irq     = 1'b1;
               r_next.state   = rbc_pkg::RBC_STARTUP;
               r_next.su_cnt  = '0;
               r_next.bit_cnt = '0;
               r_next.synced  = 1'b0;
            end
         end
         rbc_pkg::RBC_SLEEP: begin
            if (wake_i) begin
               r_next.state  = rbc_pkg::RBC_STARTUP;
               r_next.su_cnt = '0;
            end
         end
      endcase

      // buffer to fifo transfer, held back while overwriting
      overwrite = store && (r_reg.fill == rbc_pkg::BUF_FULL);
      push      = (r_reg.fill != 5'h00) && !overwrite;
      host_take = rd_valid_o && rd_ready_i;
      if (push && fifo_ready) begin
         r_next.rd_ptr = r_reg.rd_ptr + 4'h1;
      end
      if (store) begin
         r_next.bufm[r_reg.wr_ptr] = store_byte;
         r_next.wr_ptr = r_reg.wr_ptr + 4'h1;
         if (overwrite) begin
            r_next.rd_ptr = r_reg.rd_ptr + 4'h1;
         end
      end
      r_next.fill = r_reg.fill + {4'h0, store && !overwrite}
                    - {4'h0, push && fifo_ready};
      // count of bytes waiting for the host
      r_next.byte_cnt = r_reg.byte_cnt + {4'h0, store && !overwrite}
                        - {4'h0, host_take};
      if (store && !overwrite && r_reg.byte_cnt + 5'h01 == irq_thr) begin
         r_next.irq = 1'b1;
      end

      // control write clears buffering, restarts start-up only in receive mode (OPM_RX)
      if (ctrl_write_i) begin
         r_next.wr_ptr   = '0;
         r_next.rd_ptr   = '0;
         r_next.fill     = '0;
         r_next.byte_cnt = '0;
         r_next.bit_cnt  = '0;
         r_next.synced   = 1'b0;
         if (r_reg.state != rbc_pkg::RBC_OFF && cfg_i.op_mode == rbc_pkg::OPM_RX) begin
            r_next.state  = rbc_pkg::RBC_STARTUP;
            r_next.su_cnt = '0;
         end
      end
      // leaving the receive modes parks the sequencer
      if (!cfg_i.op_mode[1]) begin
         r_next.state = rbc_pkg::RBC_OFF;
      end
      // status read clears; a same-cycle event wins
      irq_set = (enter_rx && !cfg_i.t_mode && !cfg_i.p_mode) || rx_err
                || (store && !overwrite && (r_reg.byte_cnt + 5'h01 == irq_thr));
      if (irq_clear_i && !irq_set) begin
         r_next.irq = 1'b0;
      end
      // mode flags kept in flops so the outputs need no decode
      r_next.sleep = (r_next.state == rbc_pkg::RBC_SLEEP);
      r_next.recv  = (r_next.state == rbc_pkg::RBC_RECV);
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         r_reg          <= '0;
         r_reg.state    <= rbc_pkg::RBC_OFF;
         r_reg.sdo_oe_n <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   // fifo between buffer and host read port
   rbc_fifo #(
      .WIDTH (rbc_pkg::BYTE_W),
      .DEPTH (rbc_pkg::FIFO_DEPTH)
   ) i_rbc_fifo (
      .clk_i       (clk_i),
      .rst_n_i     (rst_n_i),
      .flush_i     (ctrl_write_i),
      .in_valid_i  (push),
      .in_ready_o  (fifo_ready),
      .in_data_i   (r_reg.bufm[r_reg.rd_ptr]),
      .out_valid_o (rd_valid_o),
      .out_ready_i (rd_ready_i),
      .out_data_o  (rd_data_o)
   );

   // flop outputs
   assign byte_count_o        = r_reg.byte_cnt;
   assign irq_o               = r_reg.irq;
   assign supply_out_enable_o = r_reg.sup_en;
   assign clk_out_enable_o    = r_reg.clk_en;
   assign sleep_o             = r_reg.sleep;
   assign receiving_o         = r_reg.recv;
   assign serial_out_pin_o    = r_reg.sdo;
   assign serial_out_oe_n_o   = r_reg.sdo_oe_n;

endmodule : rbc_rx
`default_nettype wire

// file: rbc_rx_checker.sv
// Purpose: port assertions of rbc_rx
// Assumes: bound by port name
// Notes:   single clock domain
`timescale 1ns/1ps
`default_nettype none
module rbc_rx_checker (
   input wire logic              clk_i,               // system clock
   input wire logic              rst_n_i,             // sync reset, active low
   input wire logic              ctrl_write_i,        // control write pulse
   input wire logic              irq_clear_i,         // status read pulse
   input wire logic              rd_ready_i,          // host accepts
   input wire logic              rd_valid_o,          // byte on offer
   input wire logic              irq_o,               // interrupt pin
   input wire logic              supply_out_enable_o, // supply enable
   input wire logic              clk_out_enable_o,    // clock enable
   input wire logic              sleep_o,             // sleep mode
   input wire logic              receiving_o,         // receiving mode
   input wire logic              serial_out_oe_n_o,   // pin enable, low drives
   input wire logic [4:0]        byte_count_o,        // received byte count
   input wire rbc_pkg::rbc_cfg_t cfg_i                // control bits
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   a_entry_enables: assert property (
      $rose(receiving_o) |-> supply_out_enable_o && clk_out_enable_o) else $error("no enable");
   a_entry_irq: assert property (
      $rose(receiving_o) && !cfg_i.t_mode && !cfg_i.p_mode |-> irq_o) else $error("no irq");
   a_irq_sticky: assert property (
      irq_o && !irq_clear_i |=> irq_o) else $error("irq lost");
   a_pin_released: assert property (
      !cfg_i.t_mode [*2] |-> serial_out_oe_n_o) else $error("pin driven");
   a_count_step: assert property (
      byte_count_o <= $past(byte_count_o) + 5'h01) else $error("count jump");
   a_write_clears: assert property (
      ctrl_write_i |=> byte_count_o == 5'h00 && !rd_valid_o) else $error("not cleared");
   a_read_counts: assert property (
      rd_valid_o && rd_ready_i |=> byte_count_o <= $past(byte_count_o)) else $error("no dec");
   a_sleep_polling: assert property (
      $rose(sleep_o) |-> cfg_i.op_mode == rbc_pkg::OPM_POLLING) else $error("bad sleep");
endmodule : rbc_rx_checker
`default_nettype wire

// file: rbc_host.sv
// Purpose: host model reading the byte port
// Assumes: take_i pulses once per byte wanted
// Notes:   ready holds until the handshake edge
`timescale 1ns/1ps
`default_nettype none
module rbc_host (
   input  wire logic       clk_i,                     // clock
   input  wire logic       take_i,                    // request one byte
   input  wire logic       rd_valid_i,                // byte on offer
   input  wire logic [7:0] rd_data_i,                 // offered byte
   output var  logic       rd_ready_o = 1'b0,         // accepting
   output var  logic [7:0] got_o);                    // last byte taken
   // ready stands to the handshake edge, byte kept there
   always @(posedge clk_i) begin
      if (rd_ready_o && rd_valid_i) begin
         rd_ready_o <= 1'b0;
         got_o      <= rd_data_i;
      end else if (take_i) rd_ready_o <= 1'b1;
   end
endmodule : rbc_host
`default_nettype wire

// file: rbc_rx_tb.sv
// Purpose: self-checking bench of rbc_rx
// Assumes: limits 10 and 14, so T is 12 ticks and 2T 24
// Notes:   a tick is 20 cycles, half a bit cell 240
`timescale 1ns/1ps
`default_nettype none
module rbc_rx_tb;
   logic clk_i = 1'b0, rst_n_i = 1'b0, dm = 1'b0, cs_n = 1'b0; // clock, reset, pins
   logic [2:0] pul = 3'h0;                         // take, irq clear, ctrl write
   logic rv, rr, irq, sup, cke, slp, rx, so, oe_n; // outputs
   logic [7:0] rd, got;                            // read data
   logic [4:0] cnt;                                // byte count
   rbc_pkg::rbc_cfg_t cfg;                         // control bits
   int n_fail = 0, comparisons = 0;                // tallies
   rbc_rx i_rbc_rx (.clk_i, .rst_n_i, .demod_i(dm), .cs_n_i(cs_n), .cfg_i(cfg),
      .ctrl_write_i(pul[0]), .wake_i(1'b0), .irq_clear_i(pul[1]), .rd_ready_i(rr),
      .rd_valid_o(rv), .rd_data_o(rd), .byte_count_o(cnt), .irq_o(irq), .sleep_o(slp),
      .supply_out_enable_o(sup), .clk_out_enable_o(cke), .receiving_o(rx),
      .serial_out_pin_o(so), .serial_out_oe_n_o(oe_n));
   rbc_host i_rbc_host (.clk_i, .take_i(pul[2]), .rd_valid_i(rv), .rd_data_i(rd),
      .rd_ready_o(rr), .got_o(got));
   initial forever #25 clk_i = ~clk_i;
   task chk(input logic [15:0] g, e);
      comparisons++;
      n_fail += int'(g !== e);
      if (g !== e) $display("[FAIL] %0t got %h exp %h", $time, g, e);
   endtask : chk
   task tally_and_finish;
      if (n_fail == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : tally_and_finish
   task pulse(input logic [2:0] m); // one-cycle pulses
      @(posedge clk_i) pul <= m;
      @(posedge clk_i) pul <= 3'h0;
   endtask : pulse
   task half(input logic v); // half bit cell
      @(posedge clk_i) dm <= v;
      repeat (239) @(posedge clk_i);
   endtask : half
   task mbyte(input logic [7:0] v); // msb first, rise at centre is one
      for (int k = 7; k >= 0; k--) begin
         half(~v[k]);
         half(v[k]);
      end
   endtask : mbyte
   // hang guard
   initial begin
      repeat (60000) @(posedge clk_i);
      n_fail++;
      tally_and_finish;
   end
   initial begin
      cfg = {2'h3, 3'h0, 2'h1, 2'h0, 6'h0a, 6'h0e};
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      repeat (2) mbyte(8'h00);
      chk({rx, sup, cke, irq, oe_n}, 16'h1f);
      pulse(3'h2);
      mbyte(8'ha5);
      chk({irq, cnt}, 16'h21);
      pulse(3'h2);
      mbyte(8'h3c);
      half(1'b0);
      half(1'b1);
      repeat (600) @(posedge clk_i);
      chk({irq, rx, 1'b0, cnt}, 16'h82);
      pulse(3'h4);
      repeat (4) @(posedge clk_i);
      chk({got, 3'h0, cnt}, 16'ha501);
      cfg.t_mode <= 1'b1;
      pulse(3'h3);
      @(posedge clk_i);
      chk({rv, cnt}, 16'h0);
      repeat (2) mbyte(8'h00);
      half(1'b1);
      chk({rx, irq, so, oe_n}, 16'ha);
      cfg.op_mode <= 2'h0;
      repeat (4) @(posedge clk_i);
      cfg.op_mode <= 2'h2;
      // polling: after start-up one edge, then none before the upper limit
      repeat (2100) @(posedge clk_i);
      half(1'b0);
      repeat (200) @(posedge clk_i);
      chk(slp, 16'h1);
      tally_and_finish;
   end
endmodule : rbc_rx_tb
bind rbc_rx rbc_rx_checker i_rbc_rx_checker (
   .clk_i               (clk_i),
   .rst_n_i             (rst_n_i),
   .ctrl_write_i        (ctrl_write_i),
   .irq_clear_i         (irq_clear_i),
   .rd_ready_i          (rd_ready_i),
   .rd_valid_o          (rd_valid_o),
   .irq_o               (irq_o),
   .supply_out_enable_o (supply_out_enable_o),
   .clk_out_enable_o    (clk_out_enable_o),
   .sleep_o             (sleep_o),
   .receiving_o         (receiving_o),
   .serial_out_oe_n_o   (serial_out_oe_n_o),
   .byte_count_o        (byte_count_o),
   .cfg_i               (cfg_i)
);
`default_nettype wire
